// ### logic/wdslp_pkg.sv
// Package for the sleep-aware watchdog: register map, fields, reset values.
// Assumes an APB slave with 32-bit data and a 125 MHz system clock.
package wdslp_pkg;
	// ************************************************
	// Register map.
	// ************************************************
	localparam logic [7:0] WDSLP_CTRL_OFF = 8'h00; // watchdog_control
	localparam logic [7:0] WDSLP_STAT_OFF = 8'h04; // Sticky event status.
	localparam logic [7:0] WDSLP_IEN_OFF = 8'h08; // Interrupt enables.
	localparam logic [7:0] WDSLP_ICLR_OFF = 8'h0c; // Write one to clear.
	localparam logic [7:0] WDSLP_FLAG_OFF = 8'h10; // Timeout/power-down flags.
	// ************************************************
	// Field layout and reset values.
	// ************************************************
	localparam int WDSLP_EN_BIT = 0;
	localparam int WDSLP_PS_LSB = 1;
	localparam int WDSLP_PS_MSB = 5;
	localparam logic [4:0] WDSLP_PS_RST = 5'h0b;
	localparam logic [4:0] WDSLP_PS_MAX = 5'h12;
	localparam logic [4:0] WDSLP_PS_BASE = 5'h05;
	localparam int WDSLP_CNT_W = 23;
	localparam int WDSLP_NEV = 2; // Bit 0 time-out reset, bit 1 wake.
	// Mode configuration encodings.
	typedef enum logic [1:0] {
		WDSLP_OFF = 2'h0,
		WDSLP_SW = 2'h1,
		WDSLP_NOSLP = 2'h2,
		WDSLP_ON = 2'h3
	} wdslp_mode_t;
	// System-side event strobes and the start-up timer level toward the watchdog.
	typedef struct packed {
		logic kick;
		logic sleep_enter;
		logic int_wake;
		logic osc_fail;
		logic ost_run;
	} wdslp_sys_t;
endpackage

// ### logic/wdslp_top.sv
// Sleep-aware watchdog: counts the low-frequency oscillator, reports time-outs.
// Assumes lfo_clk_i is a free-running oscillator clock and the sys inputs are
// synchronous to clock_i; APB master follows the usual protocol.
`timescale 1ns/100ps
module wdslp_top (
	// System clock and reset.
	input wire logic clock_i,
	input wire logic reset_i,
	// Oscillator clock for the counter.
	input wire logic lfo_clk_i,
	// Configuration word and device state.
	input wire wdslp_pkg::wdslp_mode_t wdog_mode_cfg_i,
	input wire logic asleep_i,
	input wire wdslp_pkg::wdslp_sys_t sys_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Results toward reset logic, sleep controller and CPU.
	output logic wdog_reset_o,
	output logic wake_o,
	output logic timeout_flag_n_o,
	output logic powerdown_flag_n_o,
	output logic irq_o
);
	import wdslp_pkg::*;

	// ************************************************
	// Register file.
	// ************************************************
	logic sw_wdog_enable_r;
	logic [4:0] period_select_r;
	logic [WDSLP_NEV-1:0] stat_r, stat_nxt, ien_r;
	logic timeout_flag_n_r, powerdown_flag_n_r;
	logic [31:0] prdata_r;
	logic tmo_sys;

	wire wr = psel_i & penable_i & pwrite_i;
	// Read data is caught in the setup cycle, so the flop already holds it
	// through the access cycle; pready can then stay high with no wait.
	wire rd = psel_i & ~penable_i & ~pwrite_i;
	wire sel_ctrl = paddr_i == WDSLP_CTRL_OFF;
	wire sel_stat = paddr_i == WDSLP_STAT_OFF;
	wire sel_ien = paddr_i == WDSLP_IEN_OFF;
	wire sel_iclr = paddr_i == WDSLP_ICLR_OFF;
	wire sel_flag = paddr_i == WDSLP_FLAG_OFF;
	wire mapped = sel_ctrl | sel_stat | sel_ien | sel_iclr | sel_flag;
	wire [7:0] ctrl_rd = {2'b00, period_select_r, sw_wdog_enable_r};

	// Read data, with unmapped and write-only locations reading zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux = {24'h00_0000, ctrl_rd};
		end else if (sel_stat) begin
			rd_mux = {30'h0, stat_r};
		end else if (sel_ien) begin
			rd_mux = {30'h0, ien_r};
		end else if (sel_flag) begin
			rd_mux = {30'h0, powerdown_flag_n_r, timeout_flag_n_r};
		end
	end

	// Every access finishes in one access cycle; an unmapped address is
	// refused with an error, its write dropped and its read returning zero.
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign prdata_o = prdata_r;

	// Control register; reset loads the two-second period.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sw_wdog_enable_r <= 1'b0;
			period_select_r <= WDSLP_PS_RST;
		end else if (wr & sel_ctrl) begin
			sw_wdog_enable_r <= pwdata_i[WDSLP_EN_BIT];
			period_select_r <= pwdata_i[WDSLP_PS_MSB:WDSLP_PS_LSB];
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd) begin
			prdata_r <= rd_mux;
		end
	end

	// ************************************************
	// Mode decode and clear sources.
	// ************************************************
	// The watchdog counts only while this is high; at all other times it is
	// held at zero, which also covers the clear on disable.
	logic active;
	always_comb begin
		case (wdog_mode_cfg_i)
			WDSLP_ON: active = 1'b1;
			WDSLP_NOSLP: active = ~asleep_i;
			WDSLP_SW: active = sw_wdog_enable_r;
			default: active = 1'b0;
		endcase
	end

	// Sleep exit seen as a falling edge of the sleep level.
	logic asleep_r;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			asleep_r <= 1'b0;
		end else begin
			asleep_r <= asleep_i;
		end
	end
	wire sleep_exit = asleep_r & ~asleep_i;

	// Clear pulse; a disabled or held watchdog is cleared every cycle.
	wire clr_evt = sys_i.kick | sys_i.sleep_enter | sys_i.int_wake
		| sys_i.osc_fail | sleep_exit
		| sys_i.ost_run | ~active;

	// ************************************************
	// Clear crossing: toggle with acknowledge so no clear is lost.
	// ************************************************
	logic clr_tgl_r, clr_pend_r;
	logic [1:0] ack_sync_r;
	logic [2:0] clr_sync_r;
	logic lfo_ack_r;
	wire ack_seen = ack_sync_r[1] == clr_tgl_r;

	// A clear that lands while one is in flight is merged into a second
	// toggle, so the counter zeroes at least once after every request.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			clr_tgl_r <= 1'b0;
			clr_pend_r <= 1'b0;
		end else if (ack_seen & (clr_pend_r | clr_evt)) begin
			clr_tgl_r <= ~clr_tgl_r;
			clr_pend_r <= 1'b0;
		end else if (clr_evt) begin
			clr_pend_r <= 1'b1;
		end
	end

	// Acknowledge back into the system domain through two flops.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ack_sync_r <= 2'b00;
		end else begin
			ack_sync_r <= {ack_sync_r[0], lfo_ack_r};
		end
	end

	// Held-clear level for the counter; disable and start-up are levels.
	wire hold_lvl = sys_i.ost_run | ~active | clr_pend_r | ~ack_seen;
	logic hold_r;
	logic [1:0] hold_sync_r;

	// The hold is a mix of several terms; it is flopped before the crossing
	// so that a decode glitch never reaches the oscillator side as a hold.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			hold_r <= 1'b1;
		end else begin
			hold_r <= hold_lvl;
		end
	end

	// ************************************************
	// Oscillator domain counter.
	// ************************************************
	localparam int PS_W = 5;
	logic [WDSLP_CNT_W-1:0] cnt_r;
	logic lfo_tmo_tgl_r;
	logic [4:0] ps_eff;
	// Reserved codes fall back to the minimum ratio.
	assign ps_eff = (period_select_r > WDSLP_PS_MAX) ? 5'h00
		: period_select_r;
	// Terminal count is ratio minus one, ratio = 2^(code+5).
	wire [PS_W-1:0] sh = PS_W'(ps_eff + WDSLP_PS_BASE);
	wire [WDSLP_CNT_W:0] ratio = (WDSLP_CNT_W+1)'(1) << sh;
	wire [WDSLP_CNT_W-1:0] term = WDSLP_CNT_W'(ratio - 1'b1);
	// Period select is quasi-static; it is written by software well before
	// a change matters, so it is read directly in the oscillator domain.
	wire lfo_clr = clr_sync_r[2] ^ clr_sync_r[1];

	// Two-flop synchronisers into the oscillator domain, and the echo back.
	always_ff @(posedge lfo_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clr_sync_r <= 3'b000;
			hold_sync_r <= 2'b11;
			lfo_ack_r <= 1'b0;
		end else begin
			clr_sync_r <= {clr_sync_r[1:0], clr_tgl_r};
			hold_sync_r <= {hold_sync_r[0], hold_r};
			lfo_ack_r <= clr_sync_r[1];
		end
	end

	// The count only ever sees the oscillator, never the system clock.
	always_ff @(posedge lfo_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= '0;
			lfo_tmo_tgl_r <= 1'b0;
		end else if (lfo_clr | hold_sync_r[1]) begin
			cnt_r <= '0;
		end else if (cnt_r == term) begin
			cnt_r <= '0;
			lfo_tmo_tgl_r <= ~lfo_tmo_tgl_r;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// ************************************************
	// Time-out back to the system domain.
	// ************************************************
	// Each toggle from the oscillator side becomes one system-clock pulse;
	// a watchdog disabled meanwhile drops a time-out still in flight.
	logic [2:0] tmo_sync_r;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			tmo_sync_r <= 3'b000;
		end else begin
			tmo_sync_r <= {tmo_sync_r[1:0], lfo_tmo_tgl_r};
		end
	end
	assign tmo_sys = (tmo_sync_r[2] ^ tmo_sync_r[1]) & active;

	// Reset when awake, wake when asleep.
	wire rst_evt = tmo_sys & ~asleep_i;
	wire wake_evt = tmo_sys & asleep_i;
	logic wdog_reset_r, wake_r;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wdog_reset_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			wdog_reset_r <= rst_evt;
			wake_r <= wake_evt;
		end
	end
	assign wdog_reset_o = wdog_reset_r;
	assign wake_o = wake_r;

	// Active-low flags: time-out flag drops on a time-out, power-down flag only if asleep; a kick sets both high.
	// A time-out wins over a kick in the same cycle, so an event is never
	// hidden by a clear that came too late to prevent it.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			timeout_flag_n_r <= 1'b1;
			powerdown_flag_n_r <= 1'b1;
		end else if (tmo_sys) begin
			timeout_flag_n_r <= 1'b0;
			powerdown_flag_n_r <= ~asleep_i;
		end else if (sys_i.kick) begin
			timeout_flag_n_r <= 1'b1;
			powerdown_flag_n_r <= 1'b1;
		end else if (sys_i.sleep_enter) begin
			powerdown_flag_n_r <= 1'b0;
		end
	end
	assign timeout_flag_n_o = timeout_flag_n_r;
	assign powerdown_flag_n_o = powerdown_flag_n_r;

	// ************************************************
	// Interrupt status, enable and clear; set wins over clear.
	// ************************************************
	wire [WDSLP_NEV-1:0] ev = {wake_evt, rst_evt};
	wire [WDSLP_NEV-1:0] clr_bits = (wr & sel_iclr) ? pwdata_i[WDSLP_NEV-1:0]
		: '0;
	assign stat_nxt = (stat_r & ~clr_bits) | ev;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			stat_r <= '0;
			ien_r <= '0;
		end else begin
			stat_r <= stat_nxt;
			if (wr & sel_ien) begin
				ien_r <= pwdata_i[WDSLP_NEV-1:0];
			end
		end
	end
	assign irq_o = |(stat_r & ien_r);
endmodule // wdslp_top

// ### dv/wdslp_sva.sv
// Checker for the sleep-aware watchdog, bound to its top module.
// Assumes only the top ports and the single system clock domain.
`timescale 1ns/100ps
module wdslp_sva (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic reset_i,
	// Watched ports.
	input wire logic asleep_i,
	input wire wdslp_pkg::wdslp_sys_t sys_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic wdog_reset_o,
	input wire logic wake_o,
	input wire logic timeout_flag_n_o,
	input wire logic powerdown_flag_n_o
);
	import wdslp_pkg::*;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Access decodes; the unmapped check covers only places above the last register.
	wire acc = psel_i && penable_i;
	wire rd_ctrl = acc && !pwrite_i && paddr_i == WDSLP_CTRL_OFF;
	wire unmap = acc && paddr_i > WDSLP_FLAG_OFF;
	a_bite_one_cycle: assert property (wdog_reset_o |=> !wdog_reset_o)
		else $error("reset pulse too long");
	a_wake_one_cycle: assert property (wake_o |=> !wake_o)
		else $error("wake pulse too long");
	a_asleep_no_bite: assert property (
		asleep_i && $past(asleep_i) |-> !wdog_reset_o)
		else $error("reset while asleep");
	a_wake_flags: assert property (wake_o |-> ##[0:1]
		(!timeout_flag_n_o && !powerdown_flag_n_o)) else $error("wake flags");
	a_sleep_pd_low: assert property (
		sys_i.sleep_enter |-> ##[1:2] !powerdown_flag_n_o)
		else $error("power-down flag not low");
	a_kick_flags: assert property (sys_i.kick |-> ##[1:2]
		(timeout_flag_n_o && powerdown_flag_n_o)) else $error("kick flags");
	a_bite_to_low: assert property (
		wdog_reset_o |-> ##[0:1] !timeout_flag_n_o)
		else $error("time-out flag not low");
	a_ctrl_top_zero: assert property (
		rd_ctrl |-> prdata_o[31:6] == 26'h0) else $error("control top bits");
	a_unmap_error: assert property (unmap |-> pslverr_o)
		else $error("no error on unmapped access");
	a_unmap_zero: assert property (unmap && !pwrite_i |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	c_bite: cover property (wdog_reset_o);
	c_wake: cover property (wake_o);
	c_unmap: cover property (unmap);
endmodule // wdslp_sva
bind wdslp_top wdslp_sva u_wdslp_sva (.clock_i, .reset_i, .asleep_i, .sys_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pslverr_o,
	.wdog_reset_o, .wake_o, .timeout_flag_n_o, .powerdown_flag_n_o);

// ### dv/wdslp_partner.sv
// Model of the CPU and sleep controller beside the watchdog.
// Assumes bench requests last one clock, except the start-up timer level.
`timescale 1ns/100ps
module wdslp_partner (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic reset_i,
	// Bench requests and the watchdog wake pulse.
	input wire wdslp_pkg::wdslp_sys_t req_i,
	input wire logic wake_i,
	// Toward the watchdog.
	output wdslp_pkg::wdslp_sys_t sys_o,
	output logic asleep_o
);
	import wdslp_pkg::*;
	// Requests leave on a clock edge; a wake of either kind ends sleep.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sys_o <= '0;
			asleep_o <= 1'b0;
		end else begin
			sys_o <= req_i;
			if (req_i.sleep_enter)
				asleep_o <= 1'b1;
			else if (req_i.int_wake || wake_i)
				asleep_o <= 1'b0;
		end
	end
endmodule // wdslp_partner

// ### dv/tb_watchdog_timer_with_sleep_modes.sv
// Bench for the sleep-aware watchdog: APB tasks, partner, mode tables.
// Assumes a fast oscillator, so period code 0 bites in some 200 clocks.
`timescale 1ns/100ps
module tb_watchdog_timer_with_sleep_modes;
	import wdslp_pkg::*;
	logic clock_i = 0, lfo_clk_i = 0, reset_i, asleep_i, s, e, act, er;
	logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
	logic wdog_reset_o, wake_o, timeout_flag_n_o, powerdown_flag_n_o, irq_o;
	logic [7:0] paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rq;
	logic [1:0] ev, ex;
	logic [4:0] cd [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
	wdslp_mode_t wdog_mode_cfg_i = WDSLP_OFF, m;
	wdslp_sys_t sys_i, rqs = '0;
	int miscompares = 0, n_compared = 0, n, lo;
	// Oscillator period 46 ns, unrelated in phase to the 8 ns clock.
	always #4 clock_i = ~clock_i;
	always #23 lfo_clk_i = ~lfo_clk_i;
	wdslp_top u_wdslp_top (.clock_i, .reset_i, .lfo_clk_i, .wdog_mode_cfg_i,
		.asleep_i, .sys_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .wdog_reset_o, .wake_o,
		.timeout_flag_n_o, .powerdown_flag_n_o, .irq_o);
	wdslp_partner u_wdslp_partner (.clock_i, .reset_i, .req_i(rqs),
		.wake_i(wake_o), .sys_o(sys_i), .asleep_o(asleep_i));
	// ********
	// Tasks.
	// ********
	task stop_test();
		$display("compared %0d, wrong %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// One transfer: setup, then access until pready is seen high; read data
	// and the error flag are taken at that same edge, then all is released.
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1) begin
			k++;
			if (k > 50) begin
				miscompares++;
				stop_test();
			end
			@(posedge clock_i);
		end
		rq = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// Let the edge's updates settle before callers look at outputs.
		@(negedge clock_i);
	endtask
	// Bounded wait for a bite (1) or a wake (2); 0 if none came.
	task wait_ev(input int lim);
		n = 0;
		ev = 2'h0;
		while (ev == 2'h0 && n < lim) begin
			@(posedge clock_i);
			#1 n++;
			if (wake_o === 1'b1) ev = 2'h2;
			else if (wdog_reset_o === 1'b1) ev = 2'h1;
		end
	endtask
	task pulse(input int b);
		@(posedge clock_i);
		rqs[b] <= 1'b1;
		@(posedge clock_i);
		rqs[b] <= 1'b0;
	endtask
	// The gap lets a mode change reach the oscillator domain.
	task setm(input wdslp_mode_t v);
		@(posedge clock_i);
		wdog_mode_cfg_i <= v;
		repeat (30) @(posedge clock_i);
	endtask
	// ********
	// Main sequence.
	// ********
	initial begin
		reset_i = 1'b1;
		repeat (6) @(posedge clock_i);
		reset_i <= 1'b0;
		apb(WDSLP_CTRL_OFF, 0, 0);
		chk(rq, 32'h16);
		chk(32'(er), 32'h0);
		apb(WDSLP_FLAG_OFF, 0, 0);
		chk(rq, 32'h3);
		apb(WDSLP_CTRL_OFF, 1, 32'hff);
		apb(WDSLP_CTRL_OFF, 0, 0);
		chk(rq, 32'h3f);
		apb(8'h20, 1, 32'h1);
		chk(32'(er), 32'h1);
		apb(8'h20, 0, 0);
		chk(rq, 32'h0);
		chk(32'(er), 32'h1);
		$display("registers done");
		setm(WDSLP_SW);
		foreach (cd[i]) begin
			apb(WDSLP_CTRL_OFF, 1, 32'h0);
			repeat (30) @(posedge clock_i);
			apb(WDSLP_CTRL_OFF, 1, 32'({cd[i], 1'b1}));
			wait_ev(600);
			lo = (32 << (cd[i] > WDSLP_PS_MAX ? 5'h0 : cd[i])) * 46 / 8;
			chk(32'(n >= lo && n <= lo + 60), 32'h1);
		end
		$display("periods done");
		for (int i = 0; i < 6; i++) begin
			wait_ev(100);
			chk(32'(ev), 32'h0);
			pulse(i % 2 ? 4 : 1);
		end
		wait_ev(300);
		chk(32'(ev), 32'h1);
		apb(WDSLP_FLAG_OFF, 0, 0);
		chk(rq, 32'h2);
		$display("kicks done");
		for (int i = 0; i < 16; i++) begin
			m = wdslp_mode_t'(i[3:2]);
			s = i[1];
			e = i[0];
			act = m == WDSLP_ON || (m == WDSLP_NOSLP && !s);
			act = act || (m == WDSLP_SW && e);
			ex = act ? (s ? 2'h2 : 2'h1) : 2'h0;
			setm(WDSLP_OFF);
			setm(m);
			apb(WDSLP_CTRL_OFF, 1, 32'(e));
			pulse(s ? 3 : 4);
			wait_ev(300);
			chk(32'(ev), 32'(ex));
			if (asleep_i === 1'b1) pulse(2);
		end
		$display("modes done");
		@(posedge clock_i);
		rqs.ost_run <= 1'b1;
		pulse(3);
		pulse(2);
		wait_ev(400);
		chk(32'(ev), 32'h0);
		@(posedge clock_i);
		rqs.ost_run <= 1'b0;
		wait_ev(300);
		chk(32'(ev), 32'h1);
		$display("start-up hold done");
		setm(WDSLP_OFF);
		apb(WDSLP_STAT_OFF, 0, 0);
		chk(rq, 32'h3);
		apb(WDSLP_IEN_OFF, 1, 32'h2);
		chk(32'(irq_o), 32'h1);
		apb(WDSLP_ICLR_OFF, 1, 32'h2);
		chk(32'(irq_o), 32'h0);
		apb(WDSLP_IEN_OFF, 1, 32'h3);
		chk(32'(irq_o), 32'h1);
		apb(WDSLP_ICLR_OFF, 1, 32'h1);
		apb(WDSLP_STAT_OFF, 0, 0);
		chk(rq | 32'(irq_o), 32'h0);
		$display("interrupts done");
		stop_test();
	end
endmodule // tb_watchdog_timer_with_sleep_modes
